// ---- src/flag_pkg.sv ----
// constants and types shared by the status flag logic
package flag_pkg;
    localparam logic [11:0] flags_offset = 12'hfdb;
    localparam logic [11:0] op_offset = 12'h000;
    localparam logic [11:0] oper_offset = 12'h001;
    localparam logic [11:0] result_offset = 12'h002;
    localparam logic [11:0] ext_offset = 12'h003;
    // offsets are word indices, so the byte address is four times each
    localparam logic [31:0] flags_addr = 32'h00003f6c;
    localparam logic [31:0] op_addr = 32'h00000000;
    localparam logic [31:0] oper_addr = 32'h00000004;
    localparam logic [31:0] result_addr = 32'h00000008;
    localparam logic [31:0] ext_addr = 32'h0000000c;
    localparam int neg_bit = 4;
    localparam int wrap_bit = 3;
    localparam int zero_bit = 2;
    localparam int half_bit = 1;
    localparam int carry_bit = 0;
    localparam logic [4:0] flags_reset = 5'h00;
    localparam logic [7:0] byte_reset = 8'h00;
    localparam logic [3:0] op_reset = 4'h0;
    localparam logic ext_reset = 1'b0;
    typedef enum logic [3:0] {
        op_none, add_wreg_to_reg, add_literal_to_wreg,
        subtract_wreg_from_literal, subtract_wreg_from_reg,
        register_clear_op, bit_clear_op, bit_set_op, nibble_exchange_op,
        reg_to_reg_move_op, wreg_store_op, rotate_right_op, rotate_left_op,
        logic_and_op
    } op_t;
endpackage

// ---- src/flag_alu.sv ----
// combinational alu that produces result and new flag values
`timescale 1ns/1ps
`default_nettype none
module flag_alu (
    input wire logic [3:0] op,
    input wire logic [7:0] reg_value,
    input wire logic [7:0] wreg_value,
    input wire logic [4:0] flags_in,
    output logic [7:0] result,
    output logic [4:0] flags_out,
    output logic writes_flags
);
    logic [8:0] sum;
    logic [4:0] low_sum;
    logic [7:0] addend;
    logic [7:0] base;
    logic carry_in7;
    logic sub_op;
    always_comb begin
        sub_op = (op == flag_pkg::subtract_wreg_from_literal)
            || (op == flag_pkg::subtract_wreg_from_reg);
        // subtract adds the two's complement of the subtrahend
        addend = sub_op ? ~wreg_value : wreg_value;
        base = reg_value;
        sum = {1'b0, base} + {1'b0, addend} + {8'h00, sub_op};
        low_sum = {1'b0, base[3:0]} + {1'b0, addend[3:0]} + {4'h0, sub_op};
        carry_in7 = sum[7] ^ base[7] ^ addend[7];
        result = reg_value;
        flags_out = flags_in;
        writes_flags = 1'b0;
        unique case (op)
            flag_pkg::add_wreg_to_reg, flag_pkg::add_literal_to_wreg,
            flag_pkg::subtract_wreg_from_literal,
            flag_pkg::subtract_wreg_from_reg: begin
                result = sum[7:0];
                writes_flags = 1'b1;
                flags_out[flag_pkg::neg_bit] = sum[7];
                flags_out[flag_pkg::wrap_bit] = carry_in7 ^ sum[8];
                flags_out[flag_pkg::zero_bit] = (sum[7:0] == 8'h00);
                flags_out[flag_pkg::half_bit] = low_sum[4];
                // carry reads as inverted borrow on subtract
                flags_out[flag_pkg::carry_bit] = sum[8];
            end
            flag_pkg::rotate_right_op: begin
                result = {flags_in[flag_pkg::carry_bit], reg_value[7:1]};
                writes_flags = 1'b1;
                flags_out[flag_pkg::half_bit] = reg_value[4];
                flags_out[flag_pkg::carry_bit] = reg_value[0];
                flags_out[flag_pkg::neg_bit] = result[7];
                flags_out[flag_pkg::zero_bit] = (result == 8'h00);
            end
            flag_pkg::rotate_left_op: begin
                result = {reg_value[6:0], flags_in[flag_pkg::carry_bit]};
                writes_flags = 1'b1;
                flags_out[flag_pkg::half_bit] = reg_value[3];
                flags_out[flag_pkg::carry_bit] = reg_value[7];
                flags_out[flag_pkg::neg_bit] = result[7];
                flags_out[flag_pkg::zero_bit] = (result == 8'h00);
            end
            flag_pkg::logic_and_op: begin
                result = reg_value & wreg_value;
                writes_flags = 1'b1;
                flags_out[flag_pkg::neg_bit] = result[7];
                flags_out[flag_pkg::zero_bit] = (result == 8'h00);
            end
            flag_pkg::register_clear_op: begin
                result = 8'h00;
                writes_flags = 1'b1;
                flags_out[flag_pkg::zero_bit] = 1'b1;
            end
            flag_pkg::bit_clear_op, flag_pkg::bit_set_op,
            flag_pkg::nibble_exchange_op, flag_pkg::reg_to_reg_move_op,
            flag_pkg::wreg_store_op: begin
                // flags untouched, so these may safely edit the flags
                writes_flags = 1'b0;
                unique case (op)
                    flag_pkg::bit_clear_op:
                        result = reg_value & ~(8'h01 << wreg_value[2:0]);
                    flag_pkg::bit_set_op:
                        result = reg_value | (8'h01 << wreg_value[2:0]);
                    flag_pkg::nibble_exchange_op:
                        result = {reg_value[3:0], reg_value[7:4]};
                    flag_pkg::reg_to_reg_move_op:
                        result = reg_value;
                    default:
                        result = wreg_value;
                endcase
            end
            default: begin
                result = reg_value;
            end
        endcase
    end
endmodule // flag_alu
`default_nettype wire

// ---- src/alu_status_flag_logic.sv ----
// ahb-lite slave holding the arithmetic flags and an operation port
//
// The AHB-Lite slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module alu_status_flag_logic (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic [4:0] flags,
    output logic indexed_mode_enable
);
    typedef struct packed {
        logic [4:0] flags;
        logic [3:0] op;
        logic op_dest_flags;
        logic [7:0] reg_value;
        logic [7:0] wreg_value;
        logic [7:0] result;
        logic ext;
        logic wr_pending;
        logic [31:0] wr_addr;
        logic [31:0] rdata;
    } state_t;

    state_t cur;
    state_t next_cur;
    logic [7:0] alu_result;
    logic [4:0] alu_flags;
    logic alu_writes;
    logic [7:0] operand;
    logic [3:0] wr_op;
    logic wr_dest;

    always_comb begin
        wr_op = hwdata[3:0];
        wr_dest = hwdata[8];
        // reading the flag register as source works like any register
        operand = wr_dest ? {3'h0, cur.flags} : hwdata[23:16];
    end

    flag_alu alu (
        .op(wr_op),
        .reg_value(operand),
        .wreg_value(hwdata[31:24]),
        .flags_in(cur.flags),
        .result(alu_result),
        .flags_out(alu_flags),
        .writes_flags(alu_writes)
    );

    logic addr_phase;
    logic [31:0] rd_addr;

    always_comb begin
        next_cur = cur;
        addr_phase = hsel && hready && htrans[1];
        rd_addr = haddr;
        // data phase of a write: hwdata valid now
        next_cur.wr_pending = addr_phase && hwrite;
        if (addr_phase) begin
            next_cur.wr_addr = haddr;
        end
        if (cur.wr_pending) begin
            unique case (cur.wr_addr)
                flag_pkg::op_addr: begin
                    // executes at once, flags stored in this cycle
                    next_cur.op = wr_op;
                    next_cur.op_dest_flags = wr_dest;
                    next_cur.reg_value = operand;
                    next_cur.wreg_value = hwdata[31:24];
                    next_cur.result = alu_result;
                    if (wr_dest) begin
                        // result lands in the flag bits, but flag logic wins
                        // for all five bits whenever the op writes flags
                        if (alu_writes) begin
                            next_cur.flags = alu_flags;
                        end else begin
                            next_cur.flags = alu_result[4:0];
                        end
                    end else if (alu_writes) begin
                        next_cur.flags = alu_flags;
                    end
                end
                flag_pkg::flags_addr: begin
                    next_cur.flags = hwdata[4:0];
                end
                flag_pkg::ext_addr: begin
                    next_cur.ext = hwdata[0];
                end
                default: begin
                    next_cur.flags = cur.flags;
                end
            endcase
        end
        if (addr_phase && !hwrite) begin
            unique case (rd_addr)
                flag_pkg::flags_addr:
                    next_cur.rdata = {27'h0, next_cur.flags};
                // a read right behind a write must see the new value
                flag_pkg::op_addr:
                    next_cur.rdata = {next_cur.wreg_value, next_cur.reg_value,
                        7'h00, next_cur.op_dest_flags, 4'h0, next_cur.op};
                flag_pkg::result_addr:
                    next_cur.rdata = {24'h0, next_cur.result};
                flag_pkg::ext_addr:
                    next_cur.rdata = {31'h0, next_cur.ext};
                default:
                    next_cur.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cur.flags <= flag_pkg::flags_reset;
            cur.op <= flag_pkg::op_reset;
            cur.op_dest_flags <= 1'b0;
            cur.reg_value <= flag_pkg::byte_reset;
            cur.wreg_value <= flag_pkg::byte_reset;
            cur.result <= flag_pkg::byte_reset;
            cur.ext <= flag_pkg::ext_reset;
            cur.wr_pending <= 1'b0;
            cur.wr_addr <= 32'h0;
            cur.rdata <= 32'h0;
        end else begin
            cur <= next_cur;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    assign hrdata = cur.rdata;
    assign flags = cur.flags;
    assign indexed_mode_enable = cur.ext;
endmodule // alu_status_flag_logic
`default_nettype wire

// ---- sim/alu_status_flag_chk.sv ----
// port assertions for the status flag block
`timescale 1ns/1ps
`default_nettype none
module alu_status_flag_chk (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [4:0] flags,
    input wire logic indexed_mode_enable
);
    logic ap, wr_op, wr_any, rd_fl, rd_ext, ge;
    logic [8:0] sum;
    logic [3:0] op;
    assign ap = hsel && hready && htrans == 2'h2;
    assign sum = {1'h0, hwdata[23:16]} + {1'h0, hwdata[31:24]};
    assign ge = hwdata[23:16] >= hwdata[31:24];
    assign op = hwdata[3:0];
    // data phase markers, one cycle behind the taken address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {wr_op, wr_any, rd_fl, rd_ext} <= 4'h0;
        end else begin
            wr_op <= ap && hwrite && haddr == flag_pkg::op_addr;
            wr_any <= ap && hwrite;
            rd_fl <= ap && !hwrite && haddr == flag_pkg::flags_addr;
            rd_ext <= ap && !hwrite && haddr == flag_pkg::ext_addr;
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_flags_idle: assert property (!wr_any |=> $stable(flags))
        else $error("flags moved without a write");
    a_top_zero: assert property (rd_fl |-> hrdata == {27'h0, flags})
        else $error("flag read wrong");
    a_ext_read: assert property (rd_ext |-> hrdata[0] == indexed_mode_enable)
        else $error("mode read wrong");
    a_ext_idle: assert property (!wr_any |=> $stable(indexed_mode_enable))
        else $error("mode moved without a write");
    a_clear_zero: assert property (wr_op && op == 4'h5
        |=> flags == ($past(flags) | 5'h04)) else $error("clear flags wrong");
    a_keep_flags: assert property (wr_op && !hwdata[8] && op inside {[6:10]}
        |=> $stable(flags)) else $error("move op touched flags");
    a_add_flags: assert property (wr_op && op == 4'h1 && !hwdata[8]
        |=> flags[0] == $past(sum[8]) && flags[4] == $past(sum[7])
        && flags[2] == ($past(sum[7:0]) == 8'h00)) else $error("add flags wrong");
    a_sub_carry: assert property (wr_op && op == 4'h4 && !hwdata[8]
        |=> flags[0] == $past(ge)) else $error("borrow wrong");
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not okay");
endmodule // alu_status_flag_chk
bind alu_status_flag_logic alu_status_flag_chk i_alu_status_flag_chk (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .flags, .indexed_mode_enable);
`default_nettype wire

// ---- sim/tb_alu_status_flag_logic.sv ----
// self-checking bench for the status flag block
`timescale 1ns/1ps
`default_nettype none
`define chk(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin err_total++; \
    $display("MISMATCH %s exp %h got %h", nm, ex, gt); end end
module tb_alu_status_flag_logic;
    logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, hready;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q, c;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic hreadyout, hresp, indexed_mode_enable;
    logic [4:0] flags, ef = 5'h00;
    logic [31:0] dir [6] = '{32'h017f0001, 32'h01ff0002, 32'h05050004,
        32'h04030004, 32'h01800003, 32'h0ff0000d};
    int err_total = 0, checks = 0;
    assign hready = hreadyout;
    alu_status_flag_logic i_alu_status_flag_logic (.hclk, .hresetn, .hsel,
        .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
        .hreadyout, .hresp, .flags, .indexed_mode_enable);
    task automatic report_and_stop;
        if (err_total == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic wait_rdy;
        @(posedge hclk);
        for (int n = 0; hreadyout !== 1'h1; n++) begin
            if (n == 50) begin
                err_total++;
                report_and_stop;
            end
            @(posedge hclk);
        end
    endtask
    task automatic xfer(input logic [31:0] a, input logic w, logic [31:0] d);
        hsel <= 1'h1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        wait_rdy;
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy;
        q = hrdata;
    endtask
    // reference behaviour, then the same op through the bus
    task automatic do_op(input logic [31:0] c);
        logic [7:0] a, b, r, x;
        logic [8:0] s;
        logic [4:0] n;
        logic ci;
        a = c[23:16];
        b = c[31:24];
        n = ef;
        r = 8'h00;
        ci = c[3:0] inside {3, 4};
        x = ci ? ~b : b;
        s = a + x + ci;
        case (c[3:0])
            1, 2, 3, 4: begin
                r = s[7:0];
                n = {r[7], a[7] == x[7] && r[7] != a[7], r == 8'h00,
                    a[3:0] + x[3:0] + ci > 15, s[8]};
            end
            5: n[2] = 1'h1;
            6: r = a & ~(8'h01 << b[2:0]);
            7: r = a | (8'h01 << b[2:0]);
            8: r = {a[3:0], a[7:4]};
            9: r = a;
            10: r = b;
            11: {r, n[1:0]} = {ef[0], a[7:1], a[4], a[0]};
            12: {r, n[1:0]} = {a[6:0], ef[0], a[3], a[7]};
            13: r = a & b;
            default: ;
        endcase
        if (c[3:0] > 10) n[4] = r[7];
        if (c[3:0] > 10) n[2] = r == 8'h00;
        // a flag-destination op 6 to 10 (bit clear/set, swap, move, store) lands in the flag bits
        if (c[8] && c[3:0] inside {[6:10]}) n = r[4:0];
        ef = n;
        xfer(flag_pkg::op_addr, 1'h1, c);
        xfer(flag_pkg::flags_addr, 1'h0, 32'h0);
        `chk("flags read", {27'h0, n}, q)
        `chk("flags port", n, flags)
        if (!c[8] && c[3:0] != 4'h0) begin
            xfer(flag_pkg::result_addr, 1'h0, 32'h0);
            `chk("result", {24'h0, r}, q)
        end
    endtask
    initial begin
        forever #25 hclk = ~hclk;
    end
    initial begin
        void'($urandom(32'h556e11be));
        repeat (4) @(posedge hclk);
        hresetn <= 1'h1;
        `chk("flags reset", 5'h00, flags)
        for (int i = 1; i >= 0; i--) begin
            // read straight behind the write, so the port has settled
            xfer(flag_pkg::ext_addr, 1'h1, 32'(i));
            xfer(flag_pkg::ext_addr, 1'h0, 32'h0);
            `chk("mode read", 32'(i), q)
            `chk("mode", 1'(i), indexed_mode_enable)
        end
        xfer(32'h00000020, 1'h0, 32'h0);
        `chk("unmapped", 32'h0, q)
        xfer(flag_pkg::flags_addr, 1'h1, 32'hfb);
        ef = 5'h1b;
        do_op(32'h00000105);
        foreach (dir[i]) do_op(dir[i]);
        repeat (90) begin
            c = $urandom;
            c[3:0] = 4'($urandom_range(13, 0));
            c[8] = $urandom_range(3, 0) == 0;
            if (c[8]) c[23:16] = {3'h0, ef};
            do_op(c);
        end
        report_and_stop;
    end
endmodule // tb_alu_status_flag_logic
`default_nettype wire
